// [rtl/cwl_pkg.sv]
// Constants and carrier types for the cache way-lock replacement selector.
// Assumes a 32-bit APB register port and a CPU core on the request side.
package cwl_pkg;

	// ------------------------------------------------------------
	// Register map
	// ------------------------------------------------------------
	localparam logic [11:0] CWL_CTRL_OFF = 12'h000;
	localparam logic [11:0] CWL_STAT_OFF = 12'h004;
	localparam int CWL_WAY2_LOCK_BIT = 0;
	localparam int CWL_W2FORCE_BIT = 1;
	localparam int CWL_WAY3_LOCK_BIT = 8;
	localparam int CWL_W3FORCE_BIT = 9;
	localparam int CWL_PSW_DSP_BIT = 12;
	localparam logic [3:0] CWL_CTRL_RESET = 4'h0;

	// ------------------------------------------------------------
	// Status register fields
	// ------------------------------------------------------------
	localparam int CWL_ST_WAY_LSB = 0;
	localparam int CWL_ST_FILL_BIT = 2;
	localparam int CWL_ST_VALID_BIT = 3;
	localparam int CWL_ST_DSP_BIT = 4;
	localparam int CWL_ST_PREFETCH_INSTRUCTION_BIT = 5;

	// ------------------------------------------------------------
	// LRU storage
	// ------------------------------------------------------------
	localparam int CWL_ENTRIES = 256;
	localparam int CWL_IDX_W = 8;
	localparam logic [5:0] CWL_LRU_RESET = 6'h00;

	typedef logic [1:0] cwl_way_t;

	typedef struct packed {
		logic w3force;
		logic way3_lock;
		logic w2force;
		logic way2_lock;
	} cwl_ctrl_s;

	typedef struct packed {
		logic valid;
		logic prefetch;
		logic hit;
		logic [CWL_IDX_W-1:0] index;
	} cwl_req_s;

	typedef struct packed {
		logic valid;
		logic fill;
		cwl_way_t way;
	} cwl_resp_s;

	typedef struct packed {
		logic en;
		logic [CWL_IDX_W-1:0] index;
		logic [5:0] value;
	} cwl_lru_upd_s;

endpackage

// [rtl/cwl_way_select.sv]
// Way-replacement selector with way 2/3 locking for a 4-way mixed cache.
// Assumes the core reports each miss or prefetch hit as a one-cycle request,
// and writes back the new LRU bits of an entry through the update port.
`timescale 1ns/10ps
module cwl_way_select
	import cwl_pkg::*;
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic pce,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic [31:0] processor_status_word,
	input wire cwl_req_s req,
	input wire cwl_lru_upd_s lru_upd,
	output cwl_resp_s resp
);

	// ------------------------------------------------------------
	// State
	// ------------------------------------------------------------
	typedef struct packed {
		cwl_ctrl_s ctrl;
		logic [CWL_ENTRIES-1:0][5:0] lru;
		cwl_resp_s resp;
		logic cap_dsp;
		logic cap_prefetch_instruction;
		logic cap_hit;
		logic [5:0] cap_lru;
		cwl_ctrl_s cap_ctrl;
		logic [31:0] rdata;
	} cwl_state_s;

	cwl_state_s st_reg;
	cwl_state_s st_next;

	// ------------------------------------------------------------
	// LRU decode tables
	// ------------------------------------------------------------
	// Unlisted patterns fall to way 0, which is never lockable
	function automatic cwl_way_t lru_victim(input logic [5:0] lru, input logic lock2, input logic lock3);
		cwl_way_t w;
		w = 2'h0;
		unique case ({lock3, lock2})
			2'b00:
			begin
				unique case (lru)
					6'h00, 6'h04, 6'h14, 6'h20, 6'h30, 6'h34: w = 2'h3;
					6'h01, 6'h03, 6'h0b, 6'h21, 6'h29, 6'h2b: w = 2'h2;
					6'h06, 6'h07, 6'h0f, 6'h16, 6'h1e, 6'h1f: w = 2'h1;
					default: w = 2'h0;
				endcase
			end
			2'b01:
			begin
				unique case (lru)
					6'h00, 6'h01, 6'h04, 6'h14, 6'h20, 6'h21, 6'h30, 6'h34: w = 2'h3;
					6'h03, 6'h06, 6'h07, 6'h0b, 6'h0f, 6'h16, 6'h1e, 6'h1f: w = 2'h1;
					default: w = 2'h0;
				endcase
			end
			2'b10:
			begin
				unique case (lru)
					6'h00, 6'h01, 6'h03, 6'h0b, 6'h20, 6'h21, 6'h29, 6'h2b: w = 2'h2;
					6'h04, 6'h06, 6'h07, 6'h0f, 6'h14, 6'h16, 6'h1e, 6'h1f: w = 2'h1;
					default: w = 2'h0;
				endcase
			end
			2'b11:
			begin
				unique case (lru)
					6'h00, 6'h01, 6'h03, 6'h04, 6'h06, 6'h07, 6'h0b, 6'h0f, 6'h14, 6'h16, 6'h1f:
						w = 2'h1;
					6'h1e: w = 2'h1;
					default: w = 2'h0;
				endcase
			end
		endcase
		return w;
	endfunction

	// ------------------------------------------------------------
	// Victim choice
	// ------------------------------------------------------------
	function automatic cwl_resp_s pick(input logic dsp, input logic prefetch_instruction, input logic hit,
		input logic [5:0] lru, input cwl_ctrl_s c);
		cwl_resp_s r;
		r.valid = 1'b1;
		r.fill = 1'b1;
		r.way = lru_victim(lru, 1'b0, 1'b0);
		if (prefetch_instruction && hit)
		begin
			// Hit keeps the resident line; no way is overwritten
			r.fill = 1'b0;
		end
		else if (dsp)
		begin
			if (prefetch_instruction && c.w3force && c.way3_lock)
			begin
				// Both force bits set is undefined; way 3 wins here
				r.way = 2'h3;
			end
			else if (prefetch_instruction && c.w2force && c.way2_lock)
			begin
				r.way = 2'h2;
			end
			else
			begin
				r.way = lru_victim(lru, c.way2_lock, c.way3_lock);
			end
		end
		return r;
	endfunction

	// ------------------------------------------------------------
	// Bus decode
	// ------------------------------------------------------------
	logic acc_phase;
	logic setup_phase;
	logic hit_ctrl;
	logic hit_stat;
	assign acc_phase = psel && penable;
	assign setup_phase = psel && !penable;
	assign hit_ctrl = (paddr == CWL_CTRL_OFF);
	assign hit_stat = (paddr == CWL_STAT_OFF);

	// ------------------------------------------------------------
	// Next state
	// ------------------------------------------------------------
	always_comb
	begin
		st_next = st_reg;
		st_next.resp.valid = 1'b0;
		if (req.valid)
		begin
			st_next.resp = pick(processor_status_word[CWL_PSW_DSP_BIT], req.prefetch, req.hit,
				st_reg.lru[req.index], st_reg.ctrl);
			st_next.cap_dsp = processor_status_word[CWL_PSW_DSP_BIT];
			st_next.cap_prefetch_instruction = req.prefetch;
			st_next.cap_hit = req.hit;
			st_next.cap_lru = st_reg.lru[req.index];
			st_next.cap_ctrl = st_reg.ctrl;
		end
		if (lru_upd.en)
		begin
			st_next.lru[lru_upd.index] = lru_upd.value;
		end
		// Read data is latched in the setup cycle so prdata comes from a flop
		if (setup_phase && !pwrite)
		begin
			st_next.rdata = 32'h0000_0000;
			if (hit_ctrl)
			begin
				st_next.rdata[CWL_W3FORCE_BIT] = st_reg.ctrl.w3force;
				st_next.rdata[CWL_WAY3_LOCK_BIT] = st_reg.ctrl.way3_lock;
				st_next.rdata[CWL_W2FORCE_BIT] = st_reg.ctrl.w2force;
				st_next.rdata[CWL_WAY2_LOCK_BIT] = st_reg.ctrl.way2_lock;
			end
			else if (hit_stat)
			begin
				st_next.rdata[CWL_ST_WAY_LSB +: 2] = st_reg.resp.way;
				st_next.rdata[CWL_ST_FILL_BIT] = st_reg.resp.fill;
				st_next.rdata[CWL_ST_VALID_BIT] = st_reg.resp.valid;
				st_next.rdata[CWL_ST_DSP_BIT] = st_reg.cap_dsp;
				st_next.rdata[CWL_ST_PREFETCH_INSTRUCTION_BIT] = st_reg.cap_prefetch_instruction;
			end
		end
		if (acc_phase && pwrite && hit_ctrl)
		begin
			// Reserved bits are dropped; only the four control bits are kept
			st_next.ctrl.w3force = pwdata[CWL_W3FORCE_BIT];
			st_next.ctrl.way3_lock = pwdata[CWL_WAY3_LOCK_BIT];
			st_next.ctrl.w2force = pwdata[CWL_W2FORCE_BIT];
			st_next.ctrl.way2_lock = pwdata[CWL_WAY2_LOCK_BIT];
		end
	end

	// ------------------------------------------------------------
	// Registers
	// ------------------------------------------------------------
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			st_reg <= '0;
			st_reg.ctrl <= CWL_CTRL_RESET;
			st_reg.lru <= {CWL_ENTRIES{CWL_LRU_RESET}};
		end
		else if (pce)
		begin
			st_reg <= st_next;
		end
	end

	// ------------------------------------------------------------
	// Outputs
	// ------------------------------------------------------------
	// Zero wait states: every access phase completes at once
	assign pready = acc_phase;
	assign pslverr = acc_phase && !(hit_ctrl || hit_stat);
	assign prdata = st_reg.rdata;
	assign resp = st_reg.resp;

	// ------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	a_resp_follows_req: assert property (pce && req.valid |=> resp.valid)
		else $error("no answer one cycle after request");
	a_nondsp_unlocked: assert property (resp.valid && !st_reg.cap_dsp && resp.fill
		|-> resp.way == lru_victim(st_reg.cap_lru, 1'b0, 1'b0))
		else $error("non-DSP miss did not use unlocked mapping");
	a_force_way3: assert property (resp.valid && st_reg.cap_dsp && st_reg.cap_prefetch_instruction && !st_reg.cap_hit
		&& st_reg.cap_ctrl.w3force && st_reg.cap_ctrl.way3_lock |-> resp.fill && resp.way == 2'h3)
		else $error("forced prefetch did not go to way 3");
	a_force_way2: assert property (resp.valid && st_reg.cap_dsp && st_reg.cap_prefetch_instruction && !st_reg.cap_hit
		&& st_reg.cap_ctrl.w2force && st_reg.cap_ctrl.way2_lock && !st_reg.cap_ctrl.w3force
		|-> resp.fill && resp.way == 2'h2)
		else $error("forced prefetch did not go to way 2");
	a_prefetch_hit: assert property (resp.valid && st_reg.cap_prefetch_instruction && st_reg.cap_hit |-> !resp.fill)
		else $error("prefetch hit requested a fill");
	a_lock2_excluded: assert property (resp.valid && resp.fill && st_reg.cap_dsp && st_reg.cap_ctrl.way2_lock
		&& !(st_reg.cap_prefetch_instruction && st_reg.cap_ctrl.w2force) |-> resp.way != 2'h2)
		else $error("locked way 2 chosen as victim");
	a_lock3_excluded: assert property (resp.valid && resp.fill && st_reg.cap_dsp && st_reg.cap_ctrl.way3_lock
		&& !(st_reg.cap_prefetch_instruction && st_reg.cap_ctrl.w3force) |-> resp.way != 2'h3)
		else $error("locked way 3 chosen as victim");
	a_lock2_pattern: assert property (pce && req.valid && !req.prefetch && processor_status_word[CWL_PSW_DSP_BIT]
		&& st_reg.ctrl.way2_lock && !st_reg.ctrl.way3_lock && st_reg.lru[req.index] == 6'h01 |=> resp.way == 2'h3)
		else $error("way-2 locked pattern 000001 not way 3");
	a_both_pattern: assert property (pce && req.valid && !req.prefetch && processor_status_word[CWL_PSW_DSP_BIT]
		&& st_reg.ctrl.way2_lock && st_reg.ctrl.way3_lock && st_reg.lru[req.index] == 6'h1e |=> resp.way == 2'h1)
		else $error("both locked pattern 011110 not way 1");
	a_reserved_zero: assert property (acc_phase && !pwrite && hit_ctrl
		|-> prdata[31:10] == 22'h0 && prdata[7:2] == 6'h00)
		else $error("reserved control bits read nonzero");

	// ------------------------------------------------------------
	// Victim pattern checks
	// ------------------------------------------------------------
	// Literal tables, kept apart from the decode function so a slip there shows
	logic chk_force;
	logic chk_map;
	logic chk_open;
	logic chk_l2;
	logic chk_l3;
	logic [5:0] chk_lru;
	assign chk_force = st_reg.cap_prefetch_instruction && ((st_reg.cap_ctrl.w3force && st_reg.cap_ctrl.way3_lock)
		|| (st_reg.cap_ctrl.w2force && st_reg.cap_ctrl.way2_lock));
	assign chk_map = resp.valid && resp.fill && st_reg.cap_dsp && !chk_force;
	assign chk_l2 = st_reg.cap_ctrl.way2_lock;
	assign chk_l3 = st_reg.cap_ctrl.way3_lock;
	assign chk_lru = st_reg.cap_lru;
	assign chk_open = resp.valid && resp.fill && (!st_reg.cap_dsp || (chk_map && !chk_l2 && !chk_l3));

	// Way 2 only locked
	a_lock2_way3: assert property (chk_map && chk_l2 && !chk_l3
		&& chk_lru inside {6'h00, 6'h01, 6'h04, 6'h14, 6'h20, 6'h21, 6'h30, 6'h34} |-> resp.way == 2'h3)
		else $error("way-2 locked map missed way 3");
	a_lock2_way1: assert property (chk_map && chk_l2 && !chk_l3
		&& chk_lru inside {6'h03, 6'h06, 6'h07, 6'h0b, 6'h0f, 6'h16, 6'h1e, 6'h1f} |-> resp.way == 2'h1)
		else $error("way-2 locked map missed way 1");
	a_lock2_way0: assert property (chk_map && chk_l2 && !chk_l3
		&& chk_lru inside {6'h29, 6'h2b, 6'h38, 6'h39, 6'h3b, 6'h3c, 6'h3e, 6'h3f} |-> resp.way == 2'h0)
		else $error("way-2 locked map missed way 0");

	// Way 3 only locked
	a_lock3_way2: assert property (chk_map && !chk_l2 && chk_l3
		&& chk_lru inside {6'h00, 6'h01, 6'h03, 6'h0b, 6'h20, 6'h21, 6'h29, 6'h2b} |-> resp.way == 2'h2)
		else $error("way-3 locked map missed way 2");
	a_lock3_way1: assert property (chk_map && !chk_l2 && chk_l3
		&& chk_lru inside {6'h04, 6'h06, 6'h07, 6'h0f, 6'h14, 6'h16, 6'h1e, 6'h1f} |-> resp.way == 2'h1)
		else $error("way-3 locked map missed way 1");
	a_lock3_way0: assert property (chk_map && !chk_l2 && chk_l3
		&& chk_lru inside {6'h30, 6'h34, 6'h38, 6'h39, 6'h3b, 6'h3c, 6'h3e, 6'h3f} |-> resp.way == 2'h0)
		else $error("way-3 locked map missed way 0");

	// Both locked
	a_both_way1: assert property (chk_map && chk_l2 && chk_l3
		&& chk_lru inside {6'h00, 6'h01, 6'h03, 6'h04, 6'h06, 6'h07, 6'h0b, 6'h0f, 6'h14, 6'h16, 6'h1f} |-> resp.way == 2'h1)
		else $error("both locked map missed way 1");
	a_both_way0: assert property (chk_map && chk_l2 && chk_l3
		&& chk_lru inside {6'h20, 6'h21, 6'h29, 6'h2b, 6'h30, 6'h34, 6'h38, 6'h39, 6'h3b, 6'h3c, 6'h3f} |-> resp.way == 2'h0)
		else $error("both locked map missed way 0");
	a_both_unlisted: assert property (chk_map && chk_l2 && chk_l3 && chk_lru == 6'h3e |-> resp.way == 2'h0)
		else $error("both locked pattern 111110 not way 0");

	// No locking in force
	a_open_way3: assert property (chk_open && chk_lru inside {6'h00, 6'h04, 6'h14, 6'h20, 6'h30, 6'h34}
		|-> resp.way == 2'h3)
		else $error("unlocked map missed way 3");
	a_open_way2: assert property (chk_open && chk_lru inside {6'h01, 6'h03, 6'h0b, 6'h21, 6'h29, 6'h2b}
		|-> resp.way == 2'h2)
		else $error("unlocked map missed way 2");
	a_open_way1: assert property (chk_open && chk_lru inside {6'h06, 6'h07, 6'h0f, 6'h16, 6'h1e, 6'h1f}
		|-> resp.way == 2'h1)
		else $error("unlocked map missed way 1");
	a_open_way0: assert property (chk_open && chk_lru inside {6'h38, 6'h39, 6'h3b, 6'h3c, 6'h3e, 6'h3f}
		|-> resp.way == 2'h0)
		else $error("unlocked map missed way 0");
	a_odd_pattern: assert property (chk_map && !(chk_lru inside {6'h00, 6'h01, 6'h03, 6'h04, 6'h06, 6'h07,
		6'h0b, 6'h0f, 6'h14, 6'h16, 6'h1e, 6'h1f, 6'h20, 6'h21, 6'h29, 6'h2b, 6'h30, 6'h34,
		6'h38, 6'h39, 6'h3b, 6'h3c, 6'h3e, 6'h3f}) |-> resp.way == 2'h0)
		else $error("unlisted pattern took a lockable way");

	// Bus and storage
	a_miss_fills: assert property (resp.valid && !(st_reg.cap_prefetch_instruction && st_reg.cap_hit) |-> resp.fill)
		else $error("miss gave no fill");
	a_ctrl_write: assert property (pce && acc_phase && pwrite && hit_ctrl
		|=> st_reg.ctrl.w3force == $past(pwdata[CWL_W3FORCE_BIT]) && st_reg.ctrl.way3_lock == $past(pwdata[CWL_WAY3_LOCK_BIT])
		&& st_reg.ctrl.w2force == $past(pwdata[CWL_W2FORCE_BIT]) && st_reg.ctrl.way2_lock == $past(pwdata[CWL_WAY2_LOCK_BIT]))
		else $error("control write did not land");
	a_lru_write: assert property (pce && lru_upd.en
		|=> st_reg.lru[$past(lru_upd.index)] == $past(lru_upd.value))
		else $error("LRU update did not land");
	a_unmapped_err: assert property (acc_phase && !hit_ctrl && !hit_stat |-> pslverr && pready)
		else $error("unmapped access gave no error");
	a_status_read: assert property (pce && setup_phase && !pwrite && hit_stat
		|=> prdata[CWL_ST_VALID_BIT] == $past(resp.valid))
		else $error("status read lost valid flag");
	a_freeze: assert property (!pce |=> $stable(st_reg.ctrl) && $stable(resp))
		else $error("state moved with clock enable low");
	a_resp_pulse: assert property (pce && resp.valid |=> !resp.valid || $past(req.valid))
		else $error("answer stood without request");

	c_force3: cover property (resp.valid && resp.fill && resp.way == 2'h3 && st_reg.cap_ctrl.w3force);
	c_force2: cover property (resp.valid && resp.fill && resp.way == 2'h2 && st_reg.cap_ctrl.w2force);
	c_both_locked: cover property (resp.valid && st_reg.cap_dsp && st_reg.cap_ctrl.way2_lock && st_reg.cap_ctrl.way3_lock);
	c_prefetch_instruction_hit: cover property (resp.valid && !resp.fill);
	c_open_miss: cover property (chk_open && !st_reg.cap_dsp);

endmodule

// [test/cwl_core_model.sv]
// CPU core model: issues misses, prefetch hits and LRU writes.
// Assumes the selector samples requests on the rising pclk edge.
`timescale 1ns/10ps
module cwl_core_model
	import cwl_pkg::*;
(
	input wire logic pclk,
	output cwl_req_s req,
	output cwl_lru_upd_s lru_upd,
	output logic [31:0] processor_status_word
);
	initial
	begin
		req = '0;
		lru_upd = '0;
		processor_status_word = 32'h0;
	end
	// LRU write lands one edge ahead, so the request reads the new value
	task automatic access(input logic dsp, input logic pf, input logic hit, input logic [7:0] idx,
		input logic [5:0] lru, input logic upd);
	begin
		@(posedge pclk);
		lru_upd <= '{en: upd, index: idx, value: lru};
		@(posedge pclk);
		lru_upd.en <= 1'b0;
		// Other status bits inverted so only the mode flag may matter
		processor_status_word <= dsp ? 32'h0000_1000 : 32'hffff_efff;
		req <= '{valid: 1'b1, prefetch: pf, hit: hit, index: idx};
		@(posedge pclk);
		req.valid <= 1'b0;
		#1;
	end
	endtask
endmodule

// [test/tb.sv]
// Self-checking bench for the way-lock replacement selector.
// Assumes one 250 MHz clock and an APB slave that answers with pready.
`timescale 1ns/10ps
module tb
	import cwl_pkg::*;
;
	typedef struct packed
	{
		logic dsp;
		logic pf;
		logic hit;
		logic [3:0] ctrl;
		logic [2:0] mode;
	} cwl_row_s;
	logic pclk, presetn, pce, psel, penable, pwrite, pready, pslverr, err;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, psw, rd;
	cwl_req_s req;
	cwl_lru_upd_s lru_upd;
	cwl_resp_s resp;
	int error_cnt = 0;
	int total_checks = 0;
	logic [5:0] pat [24] = '{6'h00, 6'h01, 6'h03, 6'h04, 6'h06, 6'h07, 6'h0b, 6'h0f, 6'h14, 6'h16, 6'h1e, 6'h1f,
		6'h20, 6'h21, 6'h29, 6'h2b, 6'h30, 6'h34, 6'h38, 6'h39, 6'h3b, 6'h3c, 6'h3e, 6'h3f};
	// Victim per pattern: unlocked, way 2, way 3, both locked
	string way_tab [4] = '{"322311213111322233000000", "331311113111330033000000",
		"222111211111222200000000", "111111111111000000000000"};
	// Mode 0..3 mapping, 4 forced way 2, 5 forced way 3, 7 way unchecked
	// No row sets both force bits, and reserved bits are written zero
	cwl_row_s rows [14] = '{
		'{0, 1, 0, 4'h7, 0},
		'{0, 0, 0, 4'h5, 0},
		'{1, 1, 0, 4'hc, 5},
		'{1, 1, 0, 4'h7, 4},
		'{1, 1, 0, 4'h3, 4},
		'{1, 1, 0, 4'h8, 0},
		'{1, 1, 0, 4'h1, 1},
		'{1, 1, 0, 4'h4, 2},
		'{1, 1, 0, 4'h5, 3},
		'{1, 0, 0, 4'hd, 3},
		'{1, 0, 0, 4'h3, 1},
		'{1, 0, 0, 4'hc, 2},
		'{1, 0, 0, 4'h0, 0},
		'{1, 1, 1, 4'hc, 7}};

	cwl_way_select u_cwl_way_select (.pclk(pclk), .presetn(presetn), .pce(pce), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.processor_status_word(psw), .req(req), .lru_upd(lru_upd), .resp(resp));
	cwl_core_model u_cwl_core_model (.pclk(pclk), .req(req), .lru_upd(lru_upd), .processor_status_word(psw));

	function automatic cwl_way_t exp_way(input logic [2:0] m, input int i);
		if (m > 3'd3)
			return cwl_way_t'(m - 3'd2);
		return cwl_way_t'(way_tab[m][i] - 8'h30);
	endfunction
	task automatic finish_test();
	begin
		$display("Checks %0d errors %0d", total_checks, error_cnt);
		if (error_cnt == 0 && total_checks > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	end
	endtask
	task automatic cmp_word(input logic [31:0] got, input logic [31:0] exp);
	begin
		total_checks++;
		if (got !== exp)
		begin
			error_cnt++;
			$display("ERROR %0t word got %h exp %h", $time, got, exp);
		end
	end
	endtask
	// Way is skipped on a prefetch hit: nothing is loaded there
	task automatic cmp_resp(input cwl_resp_s exp, input logic all);
	begin
		total_checks++;
		if (resp.valid !== exp.valid || resp.fill !== exp.fill || (all && resp.way !== exp.way))
		begin
			error_cnt++;
			$display("ERROR %0t resp got %h exp %h", $time, resp, exp);
		end
	end
	endtask
	// Request held until pready is seen high at a rising edge
	task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
		int n;
	begin
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= wd;
		@(posedge pclk);
		penable <= 1'b1;
		n = 0;
		do
		begin
			@(posedge pclk);
			n++;
		end
		while (pready !== 1'b1 && n < 16);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		if (pready !== 1'b1)
		begin
			error_cnt++;
			finish_test();
		end
	end
	endtask

	initial
	begin
		pclk = 1'b0;
		forever #2 pclk = ~pclk;
	end
	initial
	begin
		{presetn, pce, psel, penable, pwrite, paddr, pwdata} = '0;
		pce = 1'b1;
		repeat (10) @(posedge pclk);
		presetn <= 1'b1;
		u_cwl_core_model.access(1'b0, 1'b0, 1'b0, 8'h55, 6'h00, 1'b0);
		cmp_resp('{1'b1, 1'b1, 2'd3}, 1'b1);
		apb(1'b0, CWL_CTRL_OFF, 32'h0);
		cmp_word(rd, 32'h0);
		apb(1'b1, CWL_CTRL_OFF, 32'h0000_0103);
		apb(1'b0, CWL_CTRL_OFF, 32'h0);
		cmp_word(rd, 32'h0000_0103);
		apb(1'b0, 12'h008, 32'h0);
		cmp_word({rd[30:0], err}, 32'h1);
		foreach (rows[r])
		begin
			apb(1'b1, CWL_CTRL_OFF, {22'h0, rows[r].ctrl[3:2], 6'h0, rows[r].ctrl[1:0]});
			for (int i = 0; i < 24; i++)
			begin
				u_cwl_core_model.access(rows[r].dsp, rows[r].pf, rows[r].hit, 8'(i * 9 + r), pat[i], 1'b1);
				cmp_resp('{1'b1, !rows[r].hit, exp_way(rows[r].mode, i)}, rows[r].mode != 3'd7);
			end
		end
		// Second reset in mid-run: control and stored LRU both cleared
		presetn <= 1'b0;
		repeat (3) @(posedge pclk);
		presetn <= 1'b1;
		apb(1'b0, CWL_CTRL_OFF, 32'h0);
		cmp_word(rd, 32'h0);
		u_cwl_core_model.access(1'b0, 1'b0, 1'b0, 8'd220, 6'h00, 1'b0);
		cmp_resp('{1'b1, 1'b1, 2'd3}, 1'b1);
		finish_test();
	end
endmodule
